// file: tcc_defs.svh
// Offsets, field positions, reset values and timing counts of the timer
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_A_CTRL      3'h0
`define TCC_A_CNT_LO    3'h1
`define TCC_A_CNT_HI    3'h2
`define TCC_A_CAP_LO    3'h3
`define TCC_A_CAP_HI    3'h4
`define TCC_A_IRQ_STAT  3'h5
`define TCC_A_IRQ_EN    3'h6
`define TCC_A_IRQ_CLR   3'h7
`define TCC_B_OVF_FLAG  7
`define TCC_B_EXT_FLAG  6
`define TCC_B_RX_RATE   5
`define TCC_B_TX_RATE   4
`define TCC_B_EXT_EN    3
`define TCC_B_RUN       2
`define TCC_B_CNT_SEL   1
`define TCC_B_CAP_SEL   0
`define TCC_CTRL_RST    8'h00
`define TCC_CNT_RST     16'h0000
`define TCC_MC_OSC      12
`define TCC_MC_LAST     4'hb
`define TCC_ST_LAST     4'h1
`define TCC_SAMPLE_PH   4'h9
`define TCC_UPDATE_PH   4'h4
`endif

// file: tcc_pkg.sv
// Types shared by the timer files
package tcc_pkg;
  typedef enum logic [1:0]
  {
    TCC_OFF     = 2'b00,
    TCC_RELOAD  = 2'b01,
    TCC_CAPTURE = 2'b10,
    TCC_BAUD    = 2'b11
  } tcc_mode_t;
endpackage

// file: tcc_edge.sv
// Sampled falling-edge detector for an external pin
`timescale 1ns/1ps
module tcc_edge
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic sample,
  input  wire logic pin,
  output logic      fall
);
  logic prev_q;
  logic prev_d;
  logic fall_q;
  logic fall_d;

  always_comb
  begin
    prev_d = prev_q;
    fall_d = 1'b0;
    if (sample)
    begin
      prev_d = pin;
      fall_d = prev_q & ~pin;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      fall_q <= fall_d;
    end
  end

  assign fall = fall_q;
endmodule // tcc_edge

// file: tcc_timer.sv
// Sixteen-bit timer/counter with capture, reload and baud-rate modes
//
// Functional notes
// - Control bit picks timer or event counter
// - Count is two software-reachable byte registers
// - Timer advances once per twelve-clock machine cycle
// - Count pin sampled per machine cycle; fall counts
// - Counted value appears at next cycle's update phase
// - At most one external edge per 24 periods
// - Mode decoded from rate, capture and run bits
// - Capture mode without trigger overflows set flag
// - Overflow flag drives the interrupt request
// - Trigger fall copies count into capture bytes
// - Trigger fall also sets trigger flag
// - Trigger flag can request an interrupt
// - Reload mode overflow sets flag and reloads
// - Baud mode timer advances every state time
// - Baud mode rollover sets no flag
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       count_input_pin,
  input  wire logic       capture_trigger_pin,
  output logic            irq
);
  logic [3:0]  phase_q, phase_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cap_q, cap_d;
  logic [1:0]  ien_q, ien_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic        pend_q, pend_d;
  logic        sample, mc_tick, st_tick, upd_tick;
  logic        cnt_fall, trg_fall, step;
  logic        is_ovf;
  tcc_mode_t   mode;
  logic [1:0]  pin_vec;
  logic [1:0]  fall_vec;

  // Machine cycle of twelve oscillator clocks; state time is two
  assign mc_tick  = (phase_q == `TCC_MC_LAST);
  assign st_tick  = phase_q[0];
  assign sample   = (phase_q == `TCC_SAMPLE_PH);
  assign upd_tick = (phase_q == `TCC_UPDATE_PH);

  always_comb
  begin
    phase_d = mc_tick ? 4'h0 : phase_q + 4'h1;
  end

  // Each pin has its own sampled detector; bit 0 counts, bit 1 triggers
  assign pin_vec = {capture_trigger_pin, count_input_pin};

  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_edge
      tcc_edge u_edge
      (
        .mclk   (mclk),
        .rstn   (rstn),
        .sample (sample),
        .pin    (pin_vec[gi]),
        .fall   (fall_vec[gi])
      );
    end
  endgenerate

  assign cnt_fall = fall_vec[0];
  assign trg_fall = fall_vec[1];

  always_comb
  begin
    if (!ctrl_q[`TCC_B_RUN])
      mode = TCC_OFF;
    else if (ctrl_q[`TCC_B_RX_RATE] | ctrl_q[`TCC_B_TX_RATE])
      mode = TCC_BAUD;
    else if (ctrl_q[`TCC_B_CAP_SEL])
      mode = TCC_CAPTURE;
    else
      mode = TCC_RELOAD;
  end

  // Counter edges wait for the update phase of the next cycle; the
  // sample-per-cycle scheme limits the rate to one edge per two cycles
  always_comb
  begin
    pend_d = pend_q;
    if (cnt_fall)
      pend_d = 1'b1;
    else if (upd_tick)
      pend_d = 1'b0;
  end

  always_comb
  begin
    step = 1'b0;
    case (mode)
      TCC_OFF:
        step = 1'b0;
      TCC_BAUD:
        step = ctrl_q[`TCC_B_CNT_SEL] ? (pend_q & upd_tick)
                                      : st_tick;
      TCC_RELOAD, TCC_CAPTURE:
        step = ctrl_q[`TCC_B_CNT_SEL] ? (pend_q & upd_tick)
                                      : mc_tick;
      default:
        step = 1'b0;
    endcase
  end

  assign is_ovf = step & (cnt_q == 16'hffff);

  always_comb
  begin
    cnt_d  = cnt_q;
    cap_d  = cap_q;
    ctrl_d = ctrl_q;
    ien_d  = ien_q;
    if (wr)
    begin
      case (addr)
        `TCC_A_CTRL:    ctrl_d = wdata;
        `TCC_A_CNT_LO:  cnt_d[7:0] = wdata;
        `TCC_A_CNT_HI:  cnt_d[15:8] = wdata;
        `TCC_A_CAP_LO:  cap_d[7:0] = wdata;
        `TCC_A_CAP_HI:  cap_d[15:8] = wdata;
        `TCC_A_IRQ_EN:  ien_d = wdata[1:0];
        `TCC_A_IRQ_CLR:
        begin
          if (wdata[1])
            ctrl_d[`TCC_B_OVF_FLAG] = 1'b0;
          if (wdata[0])
            ctrl_d[`TCC_B_EXT_FLAG] = 1'b0;
        end
        default: ;
      endcase
    end
    if (step)
    begin
      if (is_ovf && mode != TCC_CAPTURE)
        cnt_d = cap_q;
      else
        cnt_d = cnt_q + 16'h0001;
    end
    // Events win over a clear in the same cycle
    if (is_ovf && mode != TCC_BAUD)
      ctrl_d[`TCC_B_OVF_FLAG] = 1'b1;
    if (trg_fall && ctrl_q[`TCC_B_EXT_EN] && mode != TCC_OFF)
    begin
      ctrl_d[`TCC_B_EXT_FLAG] = 1'b1;
      if (mode == TCC_CAPTURE)
        cap_d = cnt_q;
      else if (mode == TCC_RELOAD)
        cnt_d = cap_q;
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (rd)
    begin
      case (addr)
        `TCC_A_CTRL:     rdata_d = ctrl_q;
        `TCC_A_CNT_LO:   rdata_d = cnt_q[7:0];
        `TCC_A_CNT_HI:   rdata_d = cnt_q[15:8];
        `TCC_A_CAP_LO:   rdata_d = cap_q[7:0];
        `TCC_A_CAP_HI:   rdata_d = cap_q[15:8];
        `TCC_A_IRQ_STAT: rdata_d = {6'h00, ctrl_q[`TCC_B_OVF_FLAG],
                                    ctrl_q[`TCC_B_EXT_FLAG]};
        `TCC_A_IRQ_EN:   rdata_d = {6'h00, ien_q};
        default:         rdata_d = 8'h00;
      endcase
    end
    // Next values, so irq never lags a new enable by a cycle
    irq_d = (ien_d[1] & ctrl_d[`TCC_B_OVF_FLAG])
          | (ien_d[0] & ctrl_d[`TCC_B_EXT_FLAG]);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_q <= 4'h0;
      ctrl_q  <= `TCC_CTRL_RST;
      cnt_q   <= `TCC_CNT_RST;
      cap_q   <= `TCC_CNT_RST;
      ien_q   <= 2'b00;
      rdata_q <= 8'h00;
      irq_q   <= 1'b0;
      pend_q  <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      ctrl_q  <= ctrl_d;
      cnt_q   <= cnt_d;
      cap_q   <= cap_d;
      ien_q   <= ien_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      pend_q  <= pend_d;
    end
  end

  assign rdata = rdata_q;
  assign irq   = irq_q;

  sequence s_mc_run;
    mode == TCC_CAPTURE && !ctrl_q[`TCC_B_CNT_SEL] && mc_tick && !wr;
  endsequence

  timer_step_a: assert property (@(posedge mclk) disable iff (!rstn)
    (s_mc_run and (cnt_q != 16'hffff))
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("timer did not advance per machine cycle");

  phase_wrap_a: assert property (@(posedge mclk) disable iff (!rstn)
    mc_tick |=> phase_q == 4'h0 ##11 mc_tick)
    else $error("machine cycle length wrong");

  ctr_update_a: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_fall && mode == TCC_CAPTURE && ctrl_q[`TCC_B_CNT_SEL] && !wr
    |-> ##[1:12] (upd_tick && step))
    else $error("counted edge not applied at update phase");

  off_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    mode == TCC_OFF && !wr && !trg_fall |=> $stable(cnt_q))
    else $error("count moved while off");

  ovf_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
    is_ovf && mode == TCC_CAPTURE |=> ctrl_q[`TCC_B_OVF_FLAG])
    else $error("overflow did not set flag");

  reload_val_a: assert property (@(posedge mclk) disable iff (!rstn)
    is_ovf && mode == TCC_RELOAD && !wr && !trg_fall
    |=> cnt_q == $past(cap_q))
    else $error("reload value wrong");

  capture_val_a: assert property (@(posedge mclk) disable iff (!rstn)
    trg_fall && mode == TCC_CAPTURE && ctrl_q[`TCC_B_EXT_EN]
    |=> cap_q == $past(cnt_q) && ctrl_q[`TCC_B_EXT_FLAG])
    else $error("capture or trigger flag wrong");

  baud_noflag_a: assert property (@(posedge mclk) disable iff (!rstn)
    is_ovf && mode == TCC_BAUD && !ctrl_q[`TCC_B_OVF_FLAG] && !wr
    |=> !ctrl_q[`TCC_B_OVF_FLAG])
    else $error("baud rollover set flag");

  flag_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_q[`TCC_B_OVF_FLAG] && !wr |=> ctrl_q[`TCC_B_OVF_FLAG])
    else $error("flag cleared without software");

  irq_level_a: assert property (@(posedge mclk) disable iff (!rstn)
    ien_q[1] && ctrl_q[`TCC_B_OVF_FLAG] && !wr |-> irq)
    else $error("interrupt missing for enabled flag");

  sequence s_baud_run;
    mode == TCC_BAUD && !ctrl_q[`TCC_B_CNT_SEL] && st_tick && !wr;
  endsequence

  baud_step_a: assert property (@(posedge mclk) disable iff (!rstn)
    (s_baud_run and (cnt_q != 16'hffff))
    |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("baud timer did not advance per state time");

  // One sample per machine cycle keeps detected edges apart
  edge_space_a: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_fall |=> !cnt_fall [*8])
    else $error("count edges closer than one machine cycle");

  edge_sample_a: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_fall |-> $past(sample))
    else $error("count edge seen outside sample phase");

  trg_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
    trg_fall && ctrl_q[`TCC_B_EXT_EN] && mode != TCC_OFF
    |=> ctrl_q[`TCC_B_EXT_FLAG])
    else $error("trigger fall did not set trigger flag");

  ext_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_q[`TCC_B_EXT_FLAG] && !wr |=> ctrl_q[`TCC_B_EXT_FLAG])
    else $error("trigger flag cleared without software");

  irq_ext_a: assert property (@(posedge mclk) disable iff (!rstn)
    ien_q[0] && ctrl_q[`TCC_B_EXT_FLAG] |-> irq)
    else $error("interrupt missing for trigger flag");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
    !rd |=> rdata == 8'h00)
    else $error("read data stood longer than one cycle");
endmodule // tcc_timer

// file: tcc_pins.sv
// Model of the external sources on the count and trigger pins
`timescale 1ns/1ps
module tcc_pins
(
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic cnt_go,
  input  wire logic trg_go,
  output logic      cnt_pin,
  output logic      trg_pin
);
  logic [5:0] c_q;
  logic [5:0] t_q;

  // Each low level lasts 24 clocks, so one sample always sees it
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      c_q <= 6'h00;
      t_q <= 6'h00;
    end
    else
    begin
      c_q <= cnt_go ? 6'h30 : c_q - {5'h00, |c_q};
      t_q <= trg_go ? 6'h30 : t_q - {5'h00, |t_q};
    end

  assign cnt_pin = c_q < 6'h19;
  assign trg_pin = t_q < 6'h19;
endmodule // tcc_pins

// file: tcc_timer_tb_top.sv
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_timer_tb_top;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr   = 1'b0;
  logic       rd   = 1'b0;
  logic       cg   = 1'b0;
  logic       tg   = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] lf   = 8'h46;
  logic [7:0] rdata;
  logic [7:0] v;
  logic       cpin;
  logic       tpin;
  logic       irq;
  int         num_errors = 0;
  int         checked    = 0;
  int         cyc        = 0;

  always #25 mclk = ~mclk;

  tcc_timer uut
  (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .count_input_pin(cpin),
    .capture_trigger_pin(tpin), .irq(irq)
  );

  tcc_pins pins
  (
    .mclk(mclk), .rstn(rstn), .cnt_go(cg), .trg_go(tg),
    .cnt_pin(cpin), .trg_pin(tpin)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [2:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic pulse(input bit trig);
    @(posedge mclk);
    if (trig) tg <= 1'b1; else cg <= 1'b1;
    @(posedge mclk);
    tg <= 1'b0;
    cg <= 1'b0;
    repeat (50) @(posedge mclk);
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rdr(i[2:0]);
      chk("reset value", 8'h00, v);
    end
    $display("reset test done");
    // Random start value, 120 clocks of running
    lf = lfsr(lf);
    wrr(`TCC_A_CNT_LO, lf);
    wrr(`TCC_A_CNT_HI, 8'h00);
    wrr(`TCC_A_CTRL, 8'h05);
    repeat (118) @(posedge mclk);
    wrr(`TCC_A_CTRL, 8'h00);
    rdr(`TCC_A_CNT_LO);
    chk("timer rate", lf + 8'd10, v);
    $display("timer rate test done");
    wrr(`TCC_A_CNT_LO, 8'hff);
    wrr(`TCC_A_CNT_HI, 8'hff);
    wrr(`TCC_A_IRQ_EN, 8'h02);
    wrr(`TCC_A_CTRL, 8'h05);
    repeat (20) @(posedge mclk);
    // Read while running, so only hardware can have set the flag
    rdr(`TCC_A_IRQ_STAT);
    chk("overflow status", 8'h02, v);
    chk("irq on overflow", 8'h01, {7'h00, irq});
    wrr(`TCC_A_CTRL, 8'h80);
    rdr(`TCC_A_CNT_HI);
    chk("wrapped high", 8'h00, v);
    wrr(`TCC_A_IRQ_CLR, 8'h02);
    rdr(`TCC_A_IRQ_STAT);
    chk("status cleared", 8'h00, v);
    chk("irq cleared", 8'h00, {7'h00, irq});
    $display("overflow test done");
    // Reload mode with a random reload value; one overflow in 12 clocks
    lf = lfsr(lf);
    wrr(`TCC_A_CAP_LO, lf);
    wrr(`TCC_A_CAP_HI, 8'h12);
    wrr(`TCC_A_CNT_LO, 8'hff);
    wrr(`TCC_A_CNT_HI, 8'hff);
    wrr(`TCC_A_CTRL, 8'h04);
    repeat (12) @(posedge mclk);
    rdr(`TCC_A_IRQ_STAT);
    chk("reload status", 8'h02, v);
    wrr(`TCC_A_CTRL, 8'h00);
    rdr(`TCC_A_CNT_HI);
    chk("reload high", 8'h12, v);
    $display("reload test done");
    wrr(`TCC_A_CNT_LO, 8'h00);
    wrr(`TCC_A_CNT_HI, 8'h00);
    wrr(`TCC_A_IRQ_EN, 8'h01);
    wrr(`TCC_A_CTRL, 8'h0f);
    for (int i = 0; i < 3; i++) pulse(1'b0);
    pulse(1'b1);
    // Left running: pins are idle and software never wrote the flag
    rdr(`TCC_A_CTRL);
    chk("trigger flag", 8'h4f, v);
    chk("irq on trigger", 8'h01, {7'h00, irq});
    rdr(`TCC_A_CNT_LO);
    chk("event count", 8'h03, v);
    rdr(`TCC_A_CAP_LO);
    chk("capture low", 8'h03, v);
    $display("capture test done");
    wrr(`TCC_A_IRQ_CLR, 8'h03);
    wrr(`TCC_A_CNT_LO, 8'hf0);
    wrr(`TCC_A_CNT_HI, 8'hff);
    wrr(`TCC_A_CTRL, 8'h14);
    repeat (60) @(posedge mclk);
    wrr(`TCC_A_CTRL, 8'h00);
    rdr(`TCC_A_IRQ_STAT);
    chk("baud no flag", 8'h00, v);
    rdr(`TCC_A_CNT_HI);
    chk("baud reload", 8'h00, v);
    // 62 clocks give 31 steps: 16 to roll over onto 0x0003, then 15
    rdr(`TCC_A_CNT_LO);
    chk("baud rate", 8'h12, v);
    $display("baud test done");
    close_out();
  end
endmodule // tcc_timer_tb_top
